// >>> hw/tcbd_decoder.sv
// block decoder top: byte assembly, pixel sequencing and registered results
//
// Behaviour
// R1 - two-channel unsigned block is sixteen bytes: first eight red, last eight green
// R2 - eight bytes form a 64-bit word, lowest-address byte most significant
// R3 - two-channel: first word decoded as red, second as green, unsigned procedure
// R4 - signed one-channel block is eight bytes carrying the red channel
// R5 - top 16 bits hold base, selector, multiplier; low 48 bits hold sixteen indices
// R6 - signed base is two's complement, times eight; -128 acts as -127
// R7 - bits 51..48 select one of sixteen eight-entry modifier tables
// R8 - selector 13 gives entries -1 -2 -3 -10 0 1 2 9
// R9 - pixel indices in bits 47..0; second pixel at 44..42, msb at 44
// R10 - index value counts from the leftmost table entry, zero picks first
// R11 - multiplier is unsigned 4 bits from bits 55..52
// R12 - signed, nonzero multiplier: base*8 + mod*mult*8, clamped to +-1023
// R13 - zero multiplier means one eighth: signed sum is base*8 + modifier
// R14 - non-negative signed widening to 16 bits: (x<<5) or (x>>5)
// R15 - negative signed widening: negate, widen, negate again
// R16 - wider results use replication; full 11 bits always delivered
// R17 - signed result is 11-bit two's complement, +-1023 means +-1
// R18 - signed and unsigned share one datapath apart from +4, clamp, widening
// R19 - unsigned base is times eight plus four, binary 100 appended
// R20 - unsigned adds mod*mult*8 or bare modifier, clamps to 0..2047
// R21 - unsigned widening to 16 bits: (x<<5) + (x>>6)
// R22 - all sixteen modifier tables held as constants; MOD_TABLE_DEFAULT fills only table 13, the other fifteen are zero
// R23 - pixel index fields run from the msb end, first pixel at 47..45
`timescale 1ns/1ps
`default_nettype none

module tcbd_decoder #(
   parameter logic [1023:0] MOD_TABLES = tcbd_pkg::MOD_TABLE_DEFAULT
) (
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // block byte input
   input wire logic byteValid,
   input wire logic [7:0] byteData,
   input wire logic [1:0] blockType,
   output logic byteReady,
   // pixel result output
   output logic pixValid,
   output logic pixChannel,
   output logic [3:0] pixIndex,
   output logic pixSigned,
   output logic [10:0] pixValue11,
   output logic [15:0] pixValue16
);

   tcbd_pkg::tcbd_regs_s s_q;
   tcbd_pkg::tcbd_regs_s s_d;
   logic [10:0] calc11;
   logic [15:0] calc16;
   logic byteTake;
   logic lastByte;

   ////////////////////////////////////////////////////////////////////////////
   // shared arithmetic on the word of the channel being decoded
   tcbd_pixel_calc #(
      .MOD_TABLES(MOD_TABLES)
   ) u_calc (
      .word(s_q.chan ? s_q.word1 : s_q.word0), // R3
      .pixSel(s_q.pixCnt),
      .isSigned(s_q.bType == tcbd_pkg::BT_ONE_SGN),
      .res11(calc11),
      .res16(calc16)
   );

   ////////////////////////////////////////////////////////////////////////////
   // handshake terms
   assign byteTake = byteValid && s_q.byteReady;
   assign lastByte = (s_q.bType == tcbd_pkg::BT_TWO_UNS) ? (s_q.byteCnt == tcbd_pkg::LAST_BYTE_TWO)
                                                        : (s_q.byteCnt == tcbd_pkg::LAST_BYTE_ONE);

   ////////////////////////////////////////////////////////////////////////////
   // next state: load bytes, then stream sixteen pixels per channel word
   always_comb begin
      s_d = s_q;
      s_d.pixValid = 1'b0;
      case (s_q.state)
         tcbd_pkg::ST_LOAD: begin
            if (byteTake) begin
               // block type is sampled with the first byte only
               if (s_q.byteCnt == 4'h0) begin
                  s_d.bType = blockType;
               end
               if (s_q.byteCnt[3] == 1'b0) begin
                  s_d.word0 = {s_q.word0[55:0], byteData}; // R2 R1 R4
               end else begin
                  s_d.word1 = {s_q.word1[55:0], byteData}; // R2 R1
               end
               s_d.byteCnt = s_q.byteCnt + 4'h1;
               // first byte decides length, later bytes use the latched type
               if ((s_q.byteCnt == 4'h0 && blockType != tcbd_pkg::BT_TWO_UNS && 1'b0) || 
                   (s_q.byteCnt != 4'h0 && lastByte)) begin
                  s_d.state = tcbd_pkg::ST_DECODE;
                  s_d.byteReady = 1'b0;
                  s_d.byteCnt = 4'h0;
                  s_d.chan = 1'b0;
                  s_d.pixCnt = 4'h0;
               end
            end
         end
         tcbd_pkg::ST_DECODE: begin
            s_d.pixValid = 1'b1;
            s_d.pixChannel = s_q.chan;
            s_d.pixIndex = s_q.pixCnt;
            s_d.pixSigned = (s_q.bType == tcbd_pkg::BT_ONE_SGN);
            s_d.pix11 = calc11;
            s_d.pix16 = calc16;
            s_d.pixCnt = s_q.pixCnt + 4'h1;
            if (s_q.pixCnt == tcbd_pkg::LAST_PIXEL) begin
               // red word done: green follows only for the two-channel type
               if (s_q.bType == tcbd_pkg::BT_TWO_UNS && !s_q.chan) begin
                  s_d.chan = 1'b1; // R3
               end else begin
                  s_d.state = tcbd_pkg::ST_LOAD;
                  s_d.byteReady = 1'b1;
                  s_d.chan = 1'b0;
               end
            end
         end
         default: begin
            s_d.state = tcbd_pkg::ST_LOAD;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // the one state register
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_q <= '0;
         s_q.byteReady <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign byteReady = s_q.byteReady;
   assign pixValid = s_q.pixValid;
   assign pixChannel = s_q.pixChannel;
   assign pixIndex = s_q.pixIndex;
   assign pixSigned = s_q.pixSigned;
   assign pixValue11 = s_q.pix11;
   assign pixValue16 = s_q.pix16;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_BYTE_MSB_FIRST: assert property (@(posedge mclk) disable iff (rst) // R2
      (s_q.state == tcbd_pkg::ST_LOAD && byteTake && s_q.byteCnt == 4'h1)
      |=> (s_q.word0[15:8] == $past(s_q.word0[7:0], 1) && s_q.word0[7:0] == $past(byteData)))
      else $error("byte not shifted in below the earlier byte");

   AST_ONE_CHAN_LENGTH: assert property (@(posedge mclk) disable iff (rst) // R4
      (s_q.state == tcbd_pkg::ST_LOAD && byteTake && s_q.byteCnt == tcbd_pkg::LAST_BYTE_ONE
       && s_q.bType != tcbd_pkg::BT_TWO_UNS) |=> (s_q.state == tcbd_pkg::ST_DECODE && !byteReady))
      else $error("one-channel block did not end after eight bytes");

   AST_TWO_CHAN_LENGTH: assert property (@(posedge mclk) disable iff (rst) // R1
      (s_q.state == tcbd_pkg::ST_LOAD && byteTake && s_q.byteCnt == tcbd_pkg::LAST_BYTE_ONE
       && s_q.bType == tcbd_pkg::BT_TWO_UNS) |=> (s_q.state == tcbd_pkg::ST_LOAD && byteReady))
      else $error("two-channel block ended before sixteen bytes");

   AST_GREEN_AFTER_RED: assert property (@(posedge mclk) disable iff (rst) // R3
      (pixValid && pixChannel && pixIndex == 4'h0)
      |-> ($past(pixValid) && !$past(pixChannel) && $past(pixIndex) == 4'hf))
      else $error("green channel did not follow a full red channel");

   AST_SIXTEEN_PIXELS: assert property (@(posedge mclk) disable iff (rst) // R5
      (s_q.state == tcbd_pkg::ST_DECODE && s_q.pixCnt == 4'h0)
      |-> ##1 pixValid[*8] ##1 pixValid[*8] ##0 (pixIndex == 4'hf))
      else $error("channel word did not yield sixteen pixels in a row");

   AST_SIGNED_RANGE: assert property (@(posedge mclk) disable iff (rst) // R12
      (pixValid && pixSigned) |-> ($signed(pixValue11) >= -11'sd1023))
      else $error("signed result below -1023");

   AST_UNS_WIDEN: assert property (@(posedge mclk) disable iff (rst) // R21
      (pixValid && !pixSigned) |-> (pixValue16 == {pixValue11, pixValue11[10:6]}))
      else $error("unsigned widening wrong");

   AST_SGN_WIDEN_POS: assert property (@(posedge mclk) disable iff (rst) // R14
      (pixValid && pixSigned && !pixValue11[10])
      |-> (pixValue16 == {1'b0, pixValue11[9:0], pixValue11[9:5]}))
      else $error("non-negative signed widening wrong");

   AST_SGN_WIDEN_NEG: assert property (@(posedge mclk) disable iff (rst) // R15
      (pixValid && pixSigned && pixValue11[10])
      |-> (pixValue16[15] && 16'(-pixValue16) == {1'b0, 10'(-pixValue11), 5'(10'(-pixValue11) >> 5)}))
      else $error("negative signed widening wrong");

   AST_READY_RETURNS: assert property (@(posedge mclk) disable iff (rst) // R16
      (pixValid && pixIndex == 4'hf && (pixChannel || s_q.bType != tcbd_pkg::BT_TWO_UNS))
      |-> (byteReady && !$past(byteReady)))
      else $error("input not reopened after the last pixel");

endmodule // tcbd_decoder

`default_nettype wire

// >>> hw/tcbd_pkg.sv
// package: constants, field layout and state types of the texel channel block decoder
package tcbd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // block types, latched with the first byte of a block
   localparam logic [1:0] BT_ONE_UNS = 2'h0; // one_channel_unsigned_block_type
   localparam logic [1:0] BT_ONE_SGN = 2'h1; // one_channel_signed_block_type
   localparam logic [1:0] BT_TWO_UNS = 2'h2; // two_channel_unsigned_block_type

   ////////////////////////////////////////////////////////////////////////////
   // block sizes and 64-bit word field positions
   localparam logic [3:0] LAST_BYTE_ONE = 4'h7; // eight bytes per one-channel block
   localparam logic [3:0] LAST_BYTE_TWO = 4'hf; // sixteen bytes per two-channel block
   localparam logic [3:0] LAST_PIXEL = 4'hf; // sixteen pixels per channel word
   localparam int BASE_LSB = 56; // base value in bits 63..56
   localparam int MULT_LSB = 52; // multiplier in bits 55..52
   localparam int TSEL_LSB = 48; // table selector in bits 51..48
   localparam int IDX_FIRST_LSB = 45; // first pixel index in bits 47..45
   localparam int IDX_WIDTH = 3;

   ////////////////////////////////////////////////////////////////////////////
   // arithmetic constants
   localparam logic [2:0] UNS_ROUND = 3'h4; // the +4 term, as binary 100 below the base
   localparam logic [7:0] BASE_FORBIDDEN = 8'h80; // -128 encoding
   localparam logic [7:0] BASE_SUBST = 8'h81; // treated as -127
   localparam logic signed [17:0] SGN_HI = 18'sh003ff; // +1023
   localparam logic signed [17:0] SGN_LO = -18'sh003ff; // -1023
   localparam logic signed [17:0] UNS_HI = 18'sh007ff; // 2047
   localparam logic signed [17:0] UNS_LO = 18'sh00000;

   ////////////////////////////////////////////////////////////////////////////
   // modifier tables: table t entry i sits at bits ((t*8+i)*8) +: 8, entry 0 in the lowest byte
   localparam logic [63:0] MOD_TABLE13 = {8'h09, 8'h02, 8'h01, 8'h00, 8'hf6, 8'hfd, 8'hfe, 8'hff};
   localparam logic [1023:0] MOD_TABLE_DEFAULT = {128'h0, MOD_TABLE13, 832'h0};

   ////////////////////////////////////////////////////////////////////////////
   // controller state
   typedef enum logic [0:0] {
      ST_LOAD = 1'b0,
      ST_DECODE = 1'b1
   } tcbd_state_e;

   typedef struct packed {
      tcbd_state_e state;
      logic [1:0] bType;
      logic [3:0] byteCnt;
      logic [63:0] word0;
      logic [63:0] word1;
      logic chan;
      logic [3:0] pixCnt;
      logic byteReady;
      logic pixValid;
      logic pixChannel;
      logic [3:0] pixIndex;
      logic pixSigned;
      logic [10:0] pix11;
      logic [15:0] pix16;
   } tcbd_regs_s;

endpackage

// >>> hw/tcbd_pixel_calc.sv
// pixel value arithmetic shared by the signed and unsigned paths
`timescale 1ns/1ps
`default_nettype none

module tcbd_pixel_calc #(
   parameter logic [1023:0] MOD_TABLES = tcbd_pkg::MOD_TABLE_DEFAULT
) (
   // channel word and pixel choice
   input wire logic [63:0] word,
   input wire logic [3:0] pixSel,
   input wire logic isSigned,
   // results
   output logic [10:0] res11,
   output logic [15:0] res16
);

   ////////////////////////////////////////////////////////////////////////////
   // one datapath: only the base term (sign extension, -128 substitution, +4), the clamp limits and the widening differ
   always_comb begin
      logic [7:0] baseRaw;
      logic [3:0] mult;
      logic [3:0] tsel;
      logic [2:0] idx;
      logic signed [7:0] modVal;
      logic signed [12:0] prod;
      logic signed [17:0] baseTerm;
      logic signed [17:0] modTerm;
      logic signed [17:0] sum;
      logic [10:0] mag;
      logic [15:0] wide;
      baseTerm = '0;
      modTerm = '0;
      prod = '0;
      sum = '0;
      mag = '0;
      wide = '0;
      baseRaw = word[tcbd_pkg::BASE_LSB +: 8]; // R5
      mult = word[tcbd_pkg::MULT_LSB +: 4]; // R11
      tsel = word[tcbd_pkg::TSEL_LSB +: 4]; // R7
      // pixel p index sits 3 bits lower than pixel p-1, msb first
      idx = word[(tcbd_pkg::IDX_FIRST_LSB - tcbd_pkg::IDX_WIDTH * int'(pixSel)) +: 3]; // R9 R23
      modVal = MOD_TABLES[(int'(tsel) * 8 + int'(idx)) * 8 +: 8]; // R10 R8 R22
      if (isSigned) begin
         // -128 never reaches the adder, so the range stays symmetric
         if (baseRaw == tcbd_pkg::BASE_FORBIDDEN) begin
            baseRaw = tcbd_pkg::BASE_SUBST; // R6
         end
         baseTerm = {{7{baseRaw[7]}}, baseRaw, 3'h0}; // R6
      end else begin
         baseTerm = {7'h0, baseRaw, tcbd_pkg::UNS_ROUND}; // R19 R18
      end
      prod = 13'(modVal) * 13'($signed({1'b0, mult}));
      if (mult == 4'h0) begin
         modTerm = {{10{modVal[7]}}, modVal}; // R13 R20
      end else begin
         modTerm = {{2{prod[12]}}, prod, 3'h0}; // R12 R20
      end
      sum = baseTerm + modTerm;
      if (isSigned) begin
         if (sum > tcbd_pkg::SGN_HI) begin
            sum = tcbd_pkg::SGN_HI; // R12
         end else if (sum < tcbd_pkg::SGN_LO) begin
            sum = tcbd_pkg::SGN_LO; // R12
         end
      end else begin
         if (sum > tcbd_pkg::UNS_HI) begin
            sum = tcbd_pkg::UNS_HI; // R20
         end else if (sum < tcbd_pkg::UNS_LO) begin
            sum = tcbd_pkg::UNS_LO; // R20
         end
      end
      res11 = sum[10:0]; // R17 R16
      // widening: replicate magnitude bits, never the sign
      mag = res11[10] ? 11'(-res11) : res11; // R15
      wide = {1'b0, mag[9:0], mag[9:5]}; // R14
      if (isSigned) begin
         res16 = res11[10] ? 16'(-wide) : wide; // R15
      end else begin
         res16 = {res11, res11[10:6]}; // R21
      end
   end

endmodule // tcbd_pixel_calc

`default_nettype wire

// >>> sim/tcbd_fetch_model.sv
// byte source standing in for the texture fetch unit
`timescale 1ns/1ps
`default_nettype none

module tcbd_fetch_model (
   // clock
   input wire logic mclk,
   // byte stream to the decoder
   input wire logic byteReady,
   output var logic byteValid,
   output var logic [7:0] byteData,
   output var logic [1:0] blockType
);
   ////////////////////////////////////////////////////////////////////////////
   // quiet lines at time zero
   initial begin
      byteValid = 1'b0;
      byteData = 8'h00;
      blockType = 2'h0;
   end

   // offer n bytes from the msb end, each held until the edge that takes it
   task automatic send(input logic [1:0] t, input logic [127:0] blk, input int n, input int stall,
         output logic ok);
      int g;
      logic rdy;
      ok = 1'b1;
      blockType = t;
      for (int i = 0; i < n; i++) begin
         byteValid = 1'b1;
         byteData = blk[127-8*i -: 8];
         g = 0;
         do begin
            rdy = byteReady;
            @(posedge mclk);
            #10;
            g++;
         end while (!rdy && g < 64);
         if (!rdy) ok = 1'b0;
         // type only counts with the first byte, so spoil it afterwards
         blockType = ~t;
         // a released line shows the inverse, never a stale copy
         if (stall > 0 || i == n - 1) begin
            byteValid = 1'b0;
            byteData = ~byteData;
         end
         // no trailing gap after the last byte: pixels start right behind it
         repeat ((i == n - 1) ? 0 : stall) begin
            @(posedge mclk);
            #10;
         end
      end
   endtask
endmodule // tcbd_fetch_model

`default_nettype wire

// >>> sim/test_texel_channel_block_decoder.sv
// self-checking bench of the texel channel block decoder
`timescale 1ns/1ps
`default_nettype none

module test_texel_channel_block_decoder;
   logic mclk, rst, byteValid, byteReady, pixValid, pixChannel, pixSigned;
   logic [7:0] byteData;
   logic [1:0] blockType;
   logic [3:0] pixIndex;
   logic [10:0] pixValue11;
   logic [15:0] pixValue16;
   int errors, checked;

   ////////////////////////////////////////////////////////////////////////////
   // 10 MHz clock
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;

   tcbd_decoder u_dut (.mclk(mclk), .rst(rst), .byteValid(byteValid), .byteData(byteData),
      .blockType(blockType), .byteReady(byteReady), .pixValid(pixValid), .pixChannel(pixChannel),
      .pixIndex(pixIndex), .pixSigned(pixSigned), .pixValue11(pixValue11), .pixValue16(pixValue16));
   tcbd_fetch_model u_src (.mclk(mclk), .byteReady(byteReady), .byteValid(byteValid),
      .byteData(byteData), .blockType(blockType));

   ////////////////////////////////////////////////////////////////////////////
   // comparisons and verdict
   task automatic cmpVal(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmpFlag(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic conclude;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // reference value worked out from the field layout, table 13 only filled
   task automatic expectPix(input logic [63:0] w, input int p, input logic sgn,
         output logic [10:0] v11, output logic [15:0] v16);
      int tbl[8] = '{-1, -2, -3, -10, 0, 1, 2, 9};
      int b, m, md, s, r;
      logic [2:0] ix;
      ix = w[47-3*p -: 3];
      md = (w[51:48] == 4'hd) ? tbl[ix] : 0;
      m = w[55:52];
      b = w[63:56];
      if (sgn && b > 127) b = b - 256;
      if (b == -128) b = -127;
      b = sgn ? b * 8 : b * 8 + 4;
      s = b + ((m == 0) ? md : md * m * 8);
      if (sgn) s = (s > 1023) ? 1023 : (s < -1023) ? -1023 : s;
      else s = (s > 2047) ? 2047 : (s < 0) ? 0 : s;
      v11 = s[10:0];
      if (!sgn) r = (s << 5) + (s >> 6);
      else if (s >= 0) r = (s << 5) | (s >> 5);
      else r = -(((-s) << 5) | ((-s) >> 5));
      v16 = r[15:0];
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // one block in, every pixel of it judged as it streams out
   task automatic runBlock(input logic [1:0] t, input logic [63:0] w0, input logic [63:0] w1,
         input int stall);
      int n, g;
      logic sgn, ok;
      logic [10:0] e11;
      logic [15:0] e16;
      n = (t == 2'h2) ? 32 : 16;
      sgn = (t == 2'h1);
      u_src.send(t, {w0, w1}, n / 2, stall, ok);
      g = 0;
      while (pixValid !== 1'b1 && g < 8) begin
         @(posedge mclk);
         #10;
         g++;
      end
      if (!ok || pixValid !== 1'b1) begin
         errors++;
         $display("ERROR handshake expected done seen timeout");
         conclude();
      end
      for (int k = 0; k < n; k++) begin
         expectPix((k < 16) ? w0 : w1, k % 16, sgn, e11, e16);
         cmpFlag("pixValid", 1'b1, pixValid);
         cmpVal("pixChannel", 16'(k / 16), {15'h0, pixChannel});
         cmpVal("pixIndex", 16'(k % 16), {12'h0, pixIndex});
         cmpFlag("pixSigned", sgn, pixSigned);
         cmpVal("pixValue11", {5'h0, e11}, {5'h0, pixValue11});
         cmpVal("pixValue16", e16, pixValue16);
         cmpFlag("byteReady", k == n - 1, byteReady);
         @(posedge mclk);
         #10;
      end
      cmpFlag("pixValid", 1'b0, pixValid);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic testSigned;
      runBlock(2'h1, 64'hc42d053977053977, 64'h0, 0);
      runBlock(2'h1, 64'h410dfac688fac688, 64'h0, 1);
      $display("test signed done");
   endtask

   task automatic testSignedLimits;
      runBlock(2'h1, 64'h80fdfac688fac688, 64'h0, 0);
      runBlock(2'h1, 64'h7ffd053977053977, 64'h0, 0);
      $display("test signed limits done");
   endtask

   task automatic testUnsigned;
      runBlock(2'h0, 64'h672d053977053977, 64'h0, 0);
      runBlock(2'h0, 64'hfffdfac688fac688, 64'h0, 0);
      runBlock(2'h0, 64'h00fd053977053977, 64'h0, 2);
      runBlock(2'h3, 64'h6700fac688fac688, 64'h0, 0);
      $display("test unsigned done");
   endtask

   task automatic testTwoChannel;
      runBlock(2'h2, 64'h672d053977053977, 64'h200dfac688fac688, 0);
      runBlock(2'h2, 64'hfffd053977053977, 64'h00fdfac688fac688, 3);
      $display("test two channel done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence: reset for 16 cycles, then the scenarios
   initial begin
      errors = 0;
      checked = 0;
      rst = 1'b1;
      repeat (3) @(posedge mclk);
      #10;
      cmpFlag("byteReady", 1'b1, byteReady);
      cmpFlag("pixValid", 1'b0, pixValid);
      repeat (13) @(posedge mclk);
      #10;
      rst = 1'b0;
      testSigned();
      testSignedLimits();
      testUnsigned();
      testTwoChannel();
      conclude();
   end
endmodule // test_texel_channel_block_decoder

`default_nettype wire
